// [constellation_symbol_decoder_tb_top.sv]
// Self-checking bench for the symbol decoder
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin bad_count++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module constellation_symbol_decoder_tb_top;
  // Row: switches, levels, expected group and length
  typedef struct packed {logic ph; logic [1:0] pts; logic [7:0] i, q; logic [3:0] g; logic [2:0] l;} csd_row_t;
  localparam csd_row_t ROWS [12] = '{
    '{1'h0, 2'h0, 8'hC0, 8'hC0, 4'h3, 3'h2}, '{1'h0, 2'h0, 8'h40, 8'hC0, 4'h1, 3'h2},
    '{1'h0, 2'h1, 8'h50, 8'h20, 4'h2, 3'h3}, '{1'h0, 2'h1, 8'hE0, 8'h90, 4'h5, 3'h3},
    '{1'h0, 2'h2, 8'hA0, 8'h10, 4'hC, 3'h4}, '{1'h0, 2'h2, 8'h30, 8'h70, 4'h1, 3'h4},
    '{1'h0, 2'h3, 8'hD0, 8'hC0, 4'hA, 3'h4}, '{1'h1, 2'h0, 8'hFF, 8'h80, 4'h0, 3'h2},
    '{1'h1, 2'h0, 8'h80, 8'hFF, 4'h1, 3'h2}, '{1'h1, 2'h0, 8'h00, 8'h80, 4'h3, 3'h2},
    '{1'h1, 2'h1, 8'h80, 8'h00, 4'h5, 3'h3}, '{1'h1, 2'h2, 8'h80, 8'hFF, 4'h6, 3'h4}};
  // Pins and bench state
  logic aclk = 1'b0, aresetn = 1'b0, run = 1'b1, hunt_btn = 1'b0, hunt_in = 1'b0, sw_phase = 1'b0;
  logic band_high = 1'b1;
  logic [1:0] sw_points = 2'h0;
  logic [7:0] lvl_i = 8'h80, lvl_q = 8'h80, sym_i, sym_q, held_i, held_q, sb;
  logic bit_clk, ser_data, status_led, zmark, ok, m;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  int bad_count = 0, n_tests = 0, cyc = 0, n;
  csd_src src (.aclk, .run, .lvl_i, .lvl_q, .bit_clk, .sym_i, .sym_q);
  // Short counts
  csd_decoder #(.HUNT_CYC(50), .BLINK_CYC(40), .LOST_CYC(200)) dut (.aclk, .aresetn, .sym_i, .sym_q, .bit_clk,
    .hunt_btn, .hunt_in, .sw_phase, .sw_points, .band_high, .ser_data, .status_led, .zmark, .held_i, .held_q,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  // 10 MHz clock
  always #50 aclk = ~aclk;
  // Cut a hang short
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Strap held past the latch
  task automatic rst(input logic strap);
    hunt_btn <= strap;
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (12) @(posedge aclk);
    hunt_btn <= 1'b0;
  endtask
  // Ready raised late so the slave holds
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) break;
      if (s_axi_bvalid) s_axi_bready <= 1'b1;
    end
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) break;
      if (s_axi_rvalid) s_axi_rready <= 1'b1;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // Main sequence
  initial
  begin
    rst(1'b0);
    rd(4'h4);
    `CHK({d[11], d[0]}, 2'h2)
    foreach (ROWS[k])
    begin
      sw_phase <= ROWS[k].ph;
      sw_points <= ROWS[k].pts;
      lvl_i <= ROWS[k].i;
      lvl_q <= ROWS[k].q;
      repeat (20) @(posedge bit_clk);
      rd(4'h8);
      `CHK(d[19:0], {ROWS[k].g, ROWS[k].q, ROWS[k].i})
      `CHK({held_q, held_i}, {ROWS[k].q, ROWS[k].i})
      rd(4'h4);
      `CHK(d[14:12], ROWS[k].l)
      // Stream repeats group, MSB first
      repeat (8)
      begin
        @(posedge bit_clk);
        repeat (5) @(posedge aclk);
        sb = {sb[6:0], ser_data};
      end
      ok = 1'b0;
      for (int s = 0; s < 4; s++)
      begin
        m = 1'b1;
        for (int j = 0; j < 8; j++) if (sb[7-j] !== ROWS[k].g[ROWS[k].l-1-((j+s)%ROWS[k].l)]) m = 1'b0;
        ok |= m;
      end
      `CHK(ok, 1'b1)
    end
    // Stepping, 4 points, two regions
    sw_phase <= 1'b0;
    sw_points <= 2'h0;
    repeat (12) @(posedge bit_clk);
    `CHK(status_led, 1'b0)
    hunt_in <= 1'b1;
    repeat (6) @(posedge aclk);
    `CHK(status_led, 1'b1)
    hunt_in <= 1'b0;
    hunt_btn <= 1'b1;
    repeat (4) @(posedge aclk);
    hunt_btn <= 1'b0;
    @(negedge status_led);
    rd(4'h4);
    `CHK(d[5:3], 3'h2)
    wr(4'h0, 32'h180);
    @(negedge status_led);
    rd(4'h4);
    `CHK(d[5:4], 2'h0)
    // Lost clock marks output invalid
    run <= 1'b0;
    repeat (260) @(posedge aclk);
    `CHK({status_led, zmark}, 2'h2)
    run <= 1'b1;
    repeat (40) @(posedge aclk);
    `CHK(status_led, 1'b0)
    rd(4'h2);
    `CHK({r, d}, {csd_pkg::RESP_SLVERR, 32'h0})
    // Strapped start in the single-bit mode
    rst(1'b1);
    lvl_i <= 8'hA0;
    lvl_q <= 8'h00;
    hunt_in <= 1'b1;
    repeat (8) @(posedge bit_clk);
    rd(4'h4);
    `CHK({d[14:12], d[5:3], d[0]}, 7'h11)
    rd(4'h8);
    `CHK({zmark, d[19:16]}, 5'h11)
    @(posedge status_led);
    n = 0;
    @(posedge aclk);
    while (status_led === 1'b1)
    begin
      n++;
      @(posedge aclk);
    end
    `CHK(n, 40)
    wrap_up();
  end
endmodule // constellation_symbol_decoder_tb_top
`default_nettype wire

// [csd_decoder.sv]
// Constellation symbol decoder: sampling, decision, serial out, hunt
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// R1 - Step button held at power-up selects BPSK
// R2 - Otherwise standard six-format mode is selected
// R3 - BPSK only in special mode, rest standard
// R4 - Special mode blinks indicator about once per second
// R5 - Standard mode reads phase/amplitude and point switches
// R6 - Each symbol becomes L bits, sent serially
// R7 - Serial output changes on bit clock edges
// R8 - Source supplies bit clock at bit rate
// R9 - User sets band jumper around 4 kHz
// R10 - Both inputs sampled together and decided
// R11 - Decision boundaries fixed per constellation
// R12 - Knob moves instant within one bit-wide region
// R13 - Each step moves to next adjacent region
// R14 - Step input rising edge equals button press
// R15 - Indicator lit during step, requests then ignored
// R16 - Indicator also lit when output invalid; in BPSK mode the code shows only the blink
// R17 - Marker pulse at every sampling instant
// R18 - Held samples output until next instant
// R19 - L is 2, 3 or 4 bits; the code uses L of 1 in BPSK mode
// R20 - Neighbouring points carry Gray coded groups
// R21 - Marker pulse about 2 us wide
// R22 - BPSK ignores q, switches, step; midpoint threshold
// R23 - Step past last region wraps to first
// R24 - Per-format threshold tables held as constants
module csd_decoder #(
  parameter int HUNT_CYC  = csd_pkg::HUNT_LED_CYC,
  parameter int BLINK_CYC = csd_pkg::BLINK_HALF_CYC,
  parameter int LOST_CYC  = csd_pkg::LOST_CYC
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Quantised symbol levels, offset binary
  input  wire logic [7:0]  sym_i,
  input  wire logic [7:0]  sym_q,
  // Link and front panel pins
  input  wire logic        bit_clk,
  input  wire logic        hunt_btn,
  input  wire logic        hunt_in,
  input  wire logic        sw_phase,
  input  wire logic [1:0]  sw_points,
  input  wire logic        band_high,
  // Decoder outputs
  output var  logic        ser_data,
  output var  logic        status_led,
  output var  logic        zmark,
  output var  logic [7:0]  held_i,
  output var  logic [7:0]  held_q,
  // AXI4-Lite write address
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  // AXI4-Lite write response
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  // AXI4-Lite read data
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // Whole module state
  typedef struct packed {
    logic        mode_done;   // Power-up mode latched
    logic        bpsk;        // Special mode
    logic [1:0]  boot_cnt;    // Power-up settle count
    logic        clk_d;       // Last bit clock level
    logic        btn_d;       // Last button level
    logic        hin_d;       // Last step input level
    logic        seen;        // One edge since loss
    logic        locked;      // Bit clock present
    logic [15:0] per_cnt;     // Cycles since bit edge
    logic [15:0] bit_period;  // Measured bit period
    logic [1:0]  bit_idx;     // Bit within symbol
    logic [1:0]  region;      // Sampling region
    logic        sampled;     // Sample taken this bit
    logic [3:0]  group;       // Group being decided
    logic [3:0]  out_group;   // Group being sent
    logic        ser_data;    // Serial output
    logic [7:0]  held_i;      // Held in-phase sample
    logic [7:0]  held_q;      // Held quadrature sample
    logic [4:0]  zcnt;        // Marker cycles left
    logic        zmark;       // Marker output
    logic [23:0] hunt_cnt;    // Step indicator time
    logic        hunt_req;    // Software step request
    logic [23:0] blink_cnt;   // Blink half period
    logic        blink;       // Blink phase
    logic        led;         // Indicator output
    logic [7:0]  knob;        // Decision point within region
    logic        aw_rdy;      // Write address ready
    logic        w_rdy;       // Write data ready
    logic        ar_rdy;      // Read address ready
    logic [3:0]  awaddr;      // Captured write address
    logic [31:0] wdata;       // Captured write data
    logic [3:0]  wstrb;       // Captured byte enables
    logic        bvalid;      // Write response valid
    logic [1:0]  bresp;       // Write response code
    logic        rvalid;      // Read data valid
    logic [1:0]  rresp;       // Read response code
    logic [31:0] rdata;       // Read data
  } csd_state_t;

  // Reset state: bus ready, knob mid-region
  localparam csd_state_t RST = '{
    aw_rdy  : 1'b1,
    w_rdy   : 1'b1,
    ar_rdy  : 1'b1,
    knob    : csd_pkg::KNOB_RST,
    default : '0
  };

  csd_state_t s;
  csd_state_t next_s;

  // Synchronised pins
  logic [22:0] sy;
  logic [7:0]  sy_i;
  logic [7:0]  sy_q;
  logic        sy_clk;
  logic        sy_btn;
  logic        sy_hin;
  logic        sy_phase;
  logic [1:0]  sy_pts;
  logic        sy_band;

  // Combinational helpers
  logic [2:0]  len;
  logic [1:0]  last_idx;
  logic [1:0]  nidx;
  logic [3:0]  og;
  logic [1:0]  pos;
  logic [23:0] prod;
  logic [15:0] target;
  logic        hunt_ev;
  logic [31:0] rd;

  // Group length from mode and point switch
  function automatic logic [2:0] grp_len(input logic bp, input logic [1:0] pts);
    if (bp)
      return 3'h1;
    else if (pts == csd_pkg::PTS_4)
      return 3'h2;
    else if (pts == csd_pkg::PTS_8)
      return 3'h3;
    else
      return 3'h4;
  endfunction

  // Four-level slice, Gray coded
  function automatic logic [1:0] lvl4(input logic [7:0] v);
    logic [1:0] l;
    l = {1'b0, v >= csd_pkg::LVL_LO} + {1'b0, v >= csd_pkg::LVL_MID} + {1'b0, v >= csd_pkg::LVL_HI};
    return l ^ {1'b0, l[1]};
  endfunction

  // Magnitude about mid scale
  function automatic logic [7:0] mag(input logic [7:0] v);
    return (v >= csd_pkg::LVL_MID) ? v - csd_pkg::LVL_MID : csd_pkg::LVL_MID - v;
  endfunction

  // Angle in 11.25 degree steps, 0..31
  function automatic logic [4:0] angle(input logic [7:0] vi, input logic [7:0] vq);
    logic [7:0] ai;
    logic [7:0] aq;
    logic [7:0] mn;
    logic [7:0] mx;
    logic [1:0] sub;
    logic [2:0] k;
    ai = mag(vi);
    aq = mag(vq);
    mn = (aq <= ai) ? aq : ai;
    mx = (aq <= ai) ? ai : aq;
    sub = {1'b0, {mn, 8'h00} > 16'(mx) * 16'(csd_pkg::TAN_1)}
        + {1'b0, {mn, 8'h00} > 16'(mx) * 16'(csd_pkg::TAN_2)}
        + {1'b0, {mn, 8'h00} > 16'(mx) * 16'(csd_pkg::TAN_3)};
    k = (aq <= ai) ? {1'b0, sub} : 3'h7 - {1'b0, sub};
    if (vi >= csd_pkg::LVL_MID && vq >= csd_pkg::LVL_MID)
      return {2'h0, k};
    else if (vq >= csd_pkg::LVL_MID)
      return 5'h0F - {2'h0, k};
    else if (vi < csd_pkg::LVL_MID)
      return 5'h10 + {2'h0, k};
    else
      return 5'h1F - {2'h0, k};
  endfunction

  // Symbol decision, group right-aligned
  function automatic logic [3:0] decide(input logic bp, input logic ph, input logic [1:0] pts,
                                        input logic [7:0] vi, input logic [7:0] vq);
    logic [4:0] a;
    logic [3:0] p;
    a = angle(vi, vq);
    if (bp)
      return {3'h0, vi >= csd_pkg::LVL_MID};
    else if (ph)
    begin
      // Phase arrays: round angle to nearest point
      if (pts == csd_pkg::PTS_4)
      begin
        a = a + 5'h04;
        p = {2'h0, a[4:3]};
      end
      else if (pts == csd_pkg::PTS_8)
      begin
        a = a + 5'h02;
        p = {1'b0, a[4:2]};
      end
      else
      begin
        a = a + 5'h01;
        p = a[4:1];
      end
      return p ^ {1'b0, p[3:1]};
    end
    else if (pts == csd_pkg::PTS_4)
      return {2'h0, vi >= csd_pkg::LVL_MID, vq >= csd_pkg::LVL_MID};
    else if (pts == csd_pkg::PTS_8)
      return {1'b0, lvl4(vi), vq >= csd_pkg::LVL_MID};
    else
      return {lvl4(vi), lvl4(vq)};
  endfunction

  // Register select by byte address
  function automatic csd_pkg::csd_sel_t reg_sel(input logic [3:0] addr);
    case (addr)
      csd_pkg::OFS_CTRL:   return csd_pkg::CSD_SEL_CTRL;
      csd_pkg::OFS_STATUS: return csd_pkg::CSD_SEL_STATUS;
      csd_pkg::OFS_SAMPLE: return csd_pkg::CSD_SEL_SAMPLE;
      csd_pkg::OFS_PERIOD: return csd_pkg::CSD_SEL_PERIOD;
      default:             return csd_pkg::CSD_SEL_NONE;
    endcase
  endfunction

  // Symbol level, link and panel pins pass two flops first
  csd_sync #(
    .W (23)
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     ({band_high, sw_points, sw_phase, hunt_in, hunt_btn, bit_clk, sym_q, sym_i}),
    .dout    (sy)
  );

  assign sy_i     = sy[7:0];
  assign sy_q     = sy[15:8];
  assign sy_clk   = sy[16];
  assign sy_btn   = sy[17];
  assign sy_hin   = sy[18];
  assign sy_phase = sy[19];
  assign sy_pts   = sy[21:20];
  assign sy_band  = sy[22];

  // Next-state logic
  always_comb
  begin
    next_s = s;
    // R19 group length
    len      = grp_len(s.bpsk, sy_pts);
    last_idx = 2'(len - 3'h1);
    nidx     = (s.bit_idx >= last_idx) ? 2'h0 : s.bit_idx + 2'h1;
    og       = (nidx == 2'h0) ? s.group : s.out_group;
    pos      = 2'(len - 3'h1 - {1'b0, nidx});
    // R12 knob scales instant within one bit period
    prod     = {8'h00, s.bit_period} * {16'h0000, s.knob};
    target   = prod[23:8];
    next_s.clk_d = sy_clk;
    next_s.btn_d = sy_btn;
    next_s.hin_d = sy_hin;

    // R1 latch mode once pins have settled
    if (!s.mode_done)
    begin
      next_s.boot_cnt = s.boot_cnt + 2'h1;
      if (s.boot_cnt == csd_pkg::BOOT_LAST)
      begin
        // R2 released button gives standard mode
        next_s.bpsk      = sy_btn;
        next_s.mode_done = 1'b1;
      end
    end

    // Free-running period counter, saturating
    if (s.per_cnt != 16'hFFFF)
      next_s.per_cnt = s.per_cnt + 16'h1;
    // R16 bit clock lost makes output invalid
    if (32'(s.per_cnt) >= LOST_CYC)
    begin
      next_s.locked = 1'b0;
      next_s.seen   = 1'b0;
    end

    // Marker countdown
    if (s.zcnt != 5'h00)
    begin
      next_s.zcnt  = s.zcnt - 5'h01;
      next_s.zmark = (s.zcnt != 5'h01);
    end

    if (sy_clk && !s.clk_d)
    begin
      // Bit clock rising edge: new bit
      next_s.per_cnt    = 16'h0000;
      next_s.bit_period = s.per_cnt + 16'h1;
      next_s.seen       = 1'b1;
      next_s.locked     = s.seen;
      next_s.sampled    = 1'b0;
      next_s.bit_idx    = nidx;
      // R6 new group enters at symbol start
      next_s.out_group  = og;
      // R7 output bit moves with the bit clock, MSB first
      next_s.ser_data   = og[pos];
    end
    else if (s.locked && !s.sampled && s.bit_idx == s.region && s.per_cnt >= target)
    begin
      // R10 sample both inputs together, i alone in BPSK
      next_s.sampled = 1'b1;
      // R18 held values stand until next instant
      next_s.held_i  = sy_i;
      next_s.held_q  = s.bpsk ? s.held_q : sy_q;
      // R11 fixed per-format boundaries
      // R24 thresholds come from package constants
      // R20 Gray coded groups
      // R22 BPSK uses i only, midpoint
      // R5 format switches steer the decision
      next_s.group   = decide(s.bpsk, sy_phase, sy_pts, sy_i, sy_q);
      // R17 marker at each instant
      // R21 marker width
      next_s.zcnt    = 5'(csd_pkg::ZMARK_CYC);
      next_s.zmark   = 1'b1;
    end

    // Region out of range after a format change
    if (s.region > last_idx)
      next_s.region = 2'h0;

    // R14 input edge same as button edge
    // R15 requests ignored while step indicator time runs
    // R3 stepping only in standard mode
    hunt_ev = s.mode_done && !s.bpsk && s.hunt_cnt == 24'h000000
              && ((sy_btn && !s.btn_d) || (sy_hin && !s.hin_d) || s.hunt_req);
    next_s.hunt_req = 1'b0;
    if (s.hunt_cnt != 24'h000000)
      next_s.hunt_cnt = s.hunt_cnt - 24'h000001;
    if (hunt_ev)
    begin
      // R13 step to next region
      // R23 wrap after the last
      next_s.region   = (s.region >= last_idx) ? 2'h0 : s.region + 2'h1;
      next_s.hunt_cnt = 24'(HUNT_CYC);
    end

    // R4 slow blink in special mode
    if (s.bpsk)
    begin
      if (32'(s.blink_cnt) >= BLINK_CYC - 1)
      begin
        next_s.blink_cnt = 24'h000000;
        next_s.blink     = ~s.blink;
      end
      else
        next_s.blink_cnt = s.blink_cnt + 24'h000001;
    end

    // R15 R16 indicator outside BPSK: step busy or invalid output
    next_s.led = s.bpsk ? s.blink : (s.hunt_cnt != 24'h000000 || !s.locked);

    // Read data mux, from current state
    rd = 32'h00000000;
    case (reg_sel(s_axi_araddr))
      csd_pkg::CSD_SEL_CTRL:
        rd[csd_pkg::CTRL_KNOB +: 8] = s.knob;
      csd_pkg::CSD_SEL_STATUS:
      begin
        rd[csd_pkg::ST_BPSK]        = s.bpsk;
        rd[csd_pkg::ST_LED]         = s.led;
        rd[csd_pkg::ST_INVAL]       = ~s.locked;
        rd[csd_pkg::ST_HUNT]        = (s.hunt_cnt != 24'h000000);
        rd[csd_pkg::ST_REGION +: 2] = s.region;
        rd[csd_pkg::ST_PHASE]       = sy_phase;
        rd[csd_pkg::ST_PTS +: 2]    = sy_pts;
        rd[csd_pkg::ST_BAND]        = sy_band;
        rd[csd_pkg::ST_LEN +: 3]    = len;
      end
      csd_pkg::CSD_SEL_SAMPLE:
      begin
        rd[csd_pkg::SM_I +: 8]     = s.held_i;
        rd[csd_pkg::SM_Q +: 8]     = s.held_q;
        rd[csd_pkg::SM_GROUP +: 4] = s.group;
      end
      csd_pkg::CSD_SEL_PERIOD:
        rd[15:0] = s.bit_period;
      default:
        rd = 32'h00000000;
    endcase

    // Address and data taken in either order
    if (s.aw_rdy && s_axi_awvalid)
    begin
      next_s.aw_rdy = 1'b0;
      next_s.awaddr = s_axi_awaddr;
    end
    if (s.w_rdy && s_axi_wvalid)
    begin
      next_s.w_rdy = 1'b0;
      next_s.wdata = s_axi_wdata;
      next_s.wstrb = s_axi_wstrb;
    end
    // Both held: perform write, answer
    if (!s.aw_rdy && !s.w_rdy && !s.bvalid)
    begin
      next_s.bvalid = 1'b1;
      next_s.bresp  = csd_pkg::RESP_OKAY;
      case (reg_sel(s.awaddr))
        csd_pkg::CSD_SEL_CTRL:
        begin
          if (s.wstrb[0])
            next_s.knob = s.wdata[csd_pkg::CTRL_KNOB +: 8];
          if (s.wstrb[1] && s.wdata[csd_pkg::CTRL_HUNT])
            next_s.hunt_req = 1'b1;
        end
        csd_pkg::CSD_SEL_NONE:
          next_s.bresp = csd_pkg::RESP_SLVERR;
        default:
          next_s.bresp = csd_pkg::RESP_OKAY;
      endcase
    end
    if (s.bvalid && s_axi_bready)
    begin
      next_s.bvalid = 1'b0;
      next_s.aw_rdy = 1'b1;
      next_s.w_rdy  = 1'b1;
    end

    // Read: one outstanding at a time
    if (s.ar_rdy && s_axi_arvalid)
    begin
      next_s.ar_rdy = 1'b0;
      next_s.rvalid = 1'b1;
      next_s.rdata  = rd;
      next_s.rresp  = (reg_sel(s_axi_araddr) == csd_pkg::CSD_SEL_NONE) ?
                      csd_pkg::RESP_SLVERR : csd_pkg::RESP_OKAY;
    end
    if (s.rvalid && s_axi_rready)
    begin
      next_s.rvalid = 1'b0;
      next_s.ar_rdy = 1'b1;
    end
  end

  // State register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s <= RST;
    else
      s <= next_s;
  end

  // Outputs straight from state
  assign ser_data      = s.ser_data;
  assign status_led    = s.led;
  assign zmark         = s.zmark;
  assign held_i        = s.held_i;
  assign held_q        = s.held_q;
  assign s_axi_awready = s.aw_rdy;
  assign s_axi_wready  = s.w_rdy;
  assign s_axi_bresp   = s.bresp;
  assign s_axi_bvalid  = s.bvalid;
  assign s_axi_arready = s.ar_rdy;
  assign s_axi_rdata   = s.rdata;
  assign s_axi_rresp   = s.rresp;
  assign s_axi_rvalid  = s.rvalid;

endmodule // csd_decoder

`default_nettype wire

// [csd_pkg.sv]
// Constants shared by the constellation symbol decoder
package csd_pkg;

  // Clock period of aclk in ns (10 MHz)
  localparam int CLK_NS = 100;

  // Marker pulse width, least time
  localparam int ZMARK_NS  = 2000;
  localparam int ZMARK_CYC = (ZMARK_NS + CLK_NS - 1) / CLK_NS;

  // Indicator on-time after a region step
  localparam int HUNT_LED_MS  = 100;
  localparam int HUNT_LED_CYC = HUNT_LED_MS * 1000000 / CLK_NS;

  // Half period of the slow blink (one blink per second)
  localparam int BLINK_HALF_MS  = 500;
  localparam int BLINK_HALF_CYC = BLINK_HALF_MS * 1000000 / CLK_NS;

  // Bit clock declared lost after this long without an edge
  localparam int LOST_US  = 1000;
  localparam int LOST_CYC = LOST_US * 1000 / CLK_NS;

  // Power-up cycles before the mode is latched
  localparam logic [1:0] BOOT_LAST = 2'h3;

  // Register byte offsets
  localparam int         ADDR_W      = 4;
  localparam logic [3:0] OFS_CTRL    = 4'h0;
  localparam logic [3:0] OFS_STATUS  = 4'h4;
  localparam logic [3:0] OFS_SAMPLE  = 4'h8;
  localparam logic [3:0] OFS_PERIOD  = 4'hC;

  // Control register fields and reset value
  localparam int         CTRL_KNOB   = 0;
  localparam int         CTRL_HUNT   = 8;
  localparam logic [7:0] KNOB_RST    = 8'h80;

  // Status register field positions
  localparam int ST_BPSK   = 0;
  localparam int ST_LED    = 1;
  localparam int ST_INVAL  = 2;
  localparam int ST_HUNT   = 3;
  localparam int ST_REGION = 4;
  localparam int ST_PHASE  = 8;
  localparam int ST_PTS    = 9;
  localparam int ST_BAND   = 11;
  localparam int ST_LEN    = 12;

  // Sample register field positions
  localparam int SM_I     = 0;
  localparam int SM_Q     = 8;
  localparam int SM_GROUP = 16;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Decision thresholds, offset binary with zero at mid scale
  localparam logic [7:0] LVL_LO  = 8'h40;
  localparam logic [7:0] LVL_MID = 8'h80;
  localparam logic [7:0] LVL_HI  = 8'hC0;

  // Tangents of 11.25, 22.5 and 33.75 degrees, scaled by 256
  localparam logic [7:0] TAN_1 = 8'h33;
  localparam logic [7:0] TAN_2 = 8'h6A;
  localparam logic [7:0] TAN_3 = 8'hAB;

  // Point count switch codes
  localparam logic [1:0] PTS_4 = 2'h0;
  localparam logic [1:0] PTS_8 = 2'h1;

  // Register select
  typedef enum logic [2:0] {
    CSD_SEL_CTRL,
    CSD_SEL_STATUS,
    CSD_SEL_SAMPLE,
    CSD_SEL_PERIOD,
    CSD_SEL_NONE
  } csd_sel_t;

endpackage

// [csd_props.sv]
// Port assertions for the symbol decoder
`timescale 1ns/100ps
`default_nettype none
module csd_props (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Link and decoder outputs
  input wire logic        bit_clk,
  input wire logic        ser_data,
  input wire logic        zmark,
  input wire logic [7:0]  held_i,
  input wire logic [7:0]  held_q,
  // Bus handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [3:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  // One domain
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_mark_width: assert property ($rose(zmark) |-> zmark[*8] ##1 zmark[*8] ##1 zmark[*4])
    else $error("marker short");
  a_held_mark: assert property ($changed({held_i, held_q}) |-> zmark)
    else $error("held value moved");
  a_ser_edge: assert property ($changed(ser_data) |-> $past(bit_clk, 3))
    else $error("data moved off edge");
  // Misaligned read refused
  a_bad_addr: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[1:0] != 2'h0
    |=> s_axi_rresp == csd_pkg::RESP_SLVERR) else $error("bad read accepted");
  a_rd_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("late read");
  a_wr_lat: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("late write");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
endmodule // csd_props
bind csd_decoder csd_props u_props (.aclk, .aresetn, .bit_clk, .ser_data, .zmark, .held_i, .held_q,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// [csd_src.sv]
// Symbol source model: bit clock and symbol levels
`timescale 1ns/100ps
`default_nettype none
module csd_src (
  // Bench control
  input  wire logic       aclk,
  input  wire logic       run,
  input  wire logic [7:0] lvl_i,
  input  wire logic [7:0] lvl_q,
  // Pins toward the decoder
  output var  logic       bit_clk,
  output var  logic [7:0] sym_i,
  output var  logic [7:0] sym_q
);
  logic [2:0] ph = 3'h0; // Phase in the 800 ns bit period
  // Levels at mid scale before traffic
  initial
  begin
    bit_clk = 1'b0;
    sym_i = 8'h80;
    sym_q = 8'h80;
  end
  always @(posedge aclk)
  begin
    ph <= run ? ph + 3'h1 : 3'h0;
    // Stands low when stopped
    bit_clk <= run && ph < 3'h4;
    if (run && ph == 3'h0)
    begin
      sym_i <= lvl_i;
      sym_q <= lvl_q;
    end
  end
endmodule // csd_src
`default_nettype wire

// [csd_sync.sv]
// Two-stage synchroniser for pins entering the aclk domain
`timescale 1ns/100ps
`default_nettype none

module csd_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // Asynchronous in, synchronised out
  input  wire logic [W-1:0] din,
  output var  logic [W-1:0] dout
);

  // Both stages in one state word
  typedef struct packed {
    logic [W-1:0] s1;   // First stage, read only by s2
    logic [W-1:0] s2;   // Second stage
  } csd_sync_t;

  csd_sync_t s;
  csd_sync_t next_s;

  // Shift one stage per clock
  always_comb
  begin
    next_s.s1 = din;
    next_s.s2 = s.s1;
  end

  // Register the stages
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s <= '0;
    else
      s <= next_s;
  end

  assign dout = s.s2;

endmodule // csd_sync

`default_nettype wire
